// ### src/mcc_map.svh
// register offsets, fields, reset values and timing counts for measurement capture control
`ifndef MCC_MAP_SVH
`define MCC_MAP_SVH

// ****************************************
// register indices and byte addresses
// ****************************************
`define MCC_IDX_APP 16'h1801
`define MCC_IDX_PER 16'h1802
`define MCC_IDX_SYNC 16'h1803
`define MCC_IDX_CHEN 16'h1808
`define MCC_IDX_STAT 16'h1810
`define MCC_ADDR_APP 32'h0000_6004
`define MCC_ADDR_PER 32'h0000_6008
`define MCC_ADDR_SYNC 32'h0000_600C
`define MCC_ADDR_CHEN 32'h0000_6020
`define MCC_ADDR_STAT 32'h0000_6040

// ****************************************
// field positions and values
// ****************************************
`define MCC_APP_CELL_BIT 0
`define MCC_APP_AUXA_BIT 1
`define MCC_APP_HOLD_BIT 15
`define MCC_PER_POLICY_BIT 12
`define MCC_PER_LEN_MIN 9'h010
`define MCC_PER_RESET 16'h0010
`define MCC_SYNC_START_BIT 0
`define MCC_SYNC_QUICK_BIT 1
`define MCC_SYNC_HOLD_BIT 15

// ****************************************
// timing
// ****************************************
`define MCC_CLK_NS 50
`define MCC_PAUSE_NS 1000
`define MCC_PAUSE_CYC ((`MCC_PAUSE_NS + `MCC_CLK_NS - 1) / `MCC_CLK_NS)
`define MCC_PAIRED_NS 2000
`define MCC_PAIRED_CYC ((`MCC_PAIRED_NS + `MCC_CLK_NS - 1) / `MCC_CLK_NS)
`define MCC_QUICK_NS 500
`define MCC_QUICK_CYC ((`MCC_QUICK_NS + `MCC_CLK_NS - 1) / `MCC_CLK_NS)

`endif

// ### src/mcc_pkg.sv
// types for measurement capture control
package mcc_pkg;
    typedef enum logic [1:0] {MCC_IDLE, MCC_HOLD_WAIT, MCC_PAIRED, MCC_QUICK} mcc_state_t;
endpackage

// ### src/mcc_top.sv
// measurement capture control with ahb-lite register slave
//
// Overview of operation
// - app bit 1 captures aux input a; with hold, balancing pauses
// - app bit 0 captures cell terminal results into result registers
// - cell terminal capture only exists in the primary chain instance
// - policy bit 12 zero refreshes periodic results every period end
// - policy one updates once per write made while it is already one; the write that sets it does not update
// - bits 8:0 hold measurements per period, reset sixteen
// - period count writes below sixteen store sixteen
// - period count accepts up to 511
// - periodic bits 15:13 and 11:9 read zero, not writable
// - sync bit 15 suspends balancing during the capture it starts
// - if balancing ran, capture waits for pause timer
// - hold request ignored when write starts no capture, except a quick request during a quick cycle
// - sync bit 1 runs a dummy quick cycle, storing nothing
// - quick cycle ignored with paired start or while paired runs
// - sync bit 0 starts paired top/bottom voltage capture
// - paired start ignored with no channel enabled or already running
// - quick and paired start bits read zero
// - capture bits are write-only triggers; zero does nothing
// - per-channel enables decide whether any channel is enabled
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "mcc_map.svh"

module mcc_top
    import mcc_pkg::*;
#(
    parameter bit IS_PRIMARY = 1'b1,
    parameter int CH_NUM = 16
)(
    input wire logic sys_clk_in, // 20 MHz clock
    input wire logic rstn_in, // async reset, low
    input wire logic clk_en_in, // freezes all state when low
    input wire logic hsel_in, // slave select
    input wire logic [31:0] haddr_in, // byte address
    input wire logic [1:0] htrans_in, // transfer type
    input wire logic hwrite_in, // write strobe
    input wire logic [2:0] hsize_in, // transfer size
    input wire logic [31:0] hwdata_in, // write data
    input wire logic hready_in, // bus ready
    input wire logic balancing_in, // balancing active (pin domain)
    input wire logic period_end_in, // periodic measurement period ended
    output logic [31:0] hrdata_out, // read data
    output logic hreadyout_out, // always ready
    output logic hresp_out, // always okay
    output logic cell_capture_out, // cell terminal capture pulse
    output logic aux_a_capture_out, // aux input a capture pulse
    output logic periodic_update_out, // periodic result update pulse
    output logic [8:0] period_count_out, // measurements per period
    output logic balance_hold_out, // balancing paused
    output logic paired_start_out, // paired capture start pulse
    output logic paired_busy_out, // paired cycle running
    output logic quick_start_out // dummy quick cycle pulse
);

    // ****************************************
    // timing constants
    // ****************************************
    localparam logic [7:0] PAUSE_CYC = 8'(`MCC_PAUSE_CYC);
    localparam logic [7:0] PAIRED_CYC = 8'(`MCC_PAIRED_CYC);
    localparam logic [7:0] QUICK_CYC = 8'(`MCC_QUICK_CYC);

    // clamp a period count to the minimum
    function automatic logic [8:0] clamp_len(input logic [8:0] v);
        clamp_len = (v < `MCC_PER_LEN_MIN) ? `MCC_PER_LEN_MIN : v;
    endfunction

    // ****************************************
    // ahb-lite slave
    // ****************************************
    logic wr_pend_r, rd_pend_r;
    logic [31:0] addr_r;
    logic bal_s1_r, bal_s2_r;
    logic policy_r;
    logic [8:0] len_r;
    logic [CH_NUM-1:0] chen_r;
    mcc_state_t state_r, state_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic hold_r, hold_nxt;
    logic cell_r, auxa_r, upd_r, pstart_r, qstart_r, pstart_nxt, qstart_nxt;
    logic [31:0] rdata_r;
    logic wait_quick_r, busy_r;

    // address phase accepted for this slave
    wire logic addr_ok = hsel_in && hready_in && htrans_in[1];
    wire logic wr_app = wr_pend_r && (addr_r == `MCC_ADDR_APP);
    wire logic wr_per = wr_pend_r && (addr_r == `MCC_ADDR_PER);
    wire logic wr_sync = wr_pend_r && (addr_r == `MCC_ADDR_SYNC);
    wire logic wr_chen = wr_pend_r && (addr_r == `MCC_ADDR_CHEN);
    wire logic any_ch = |chen_r;
    wire logic running = (state_r != MCC_IDLE);
    // app capture bits; cell capture absent in secondary chain
    wire logic cell_go = wr_app && hwdata_in[`MCC_APP_CELL_BIT] && IS_PRIMARY;
    wire logic auxa_go = wr_app && hwdata_in[`MCC_APP_AUXA_BIT];
    wire logic app_hold = wr_app && hwdata_in[`MCC_APP_HOLD_BIT] && (cell_go || auxa_go);
    // paired start wins; quick ignored beside it or during a paired cycle
    wire logic paired_go = wr_sync && hwdata_in[`MCC_SYNC_START_BIT] && any_ch && !running;
    wire logic quick_go = wr_sync && hwdata_in[`MCC_SYNC_QUICK_BIT] && !hwdata_in[`MCC_SYNC_START_BIT]
                          && (state_r != MCC_PAIRED) && (state_r != MCC_HOLD_WAIT);
    wire logic sync_hold = wr_sync && hwdata_in[`MCC_SYNC_HOLD_BIT] && (paired_go || quick_go);
    // read mux on the address phase, so the word stands through the data phase
    wire logic [31:0] rd_addr = {haddr_in[31:2], 2'b00};
    wire logic [31:0] rd_mux =
        (rd_addr == `MCC_ADDR_PER) ? {19'h0, policy_r, 3'h0, len_r} :
        (rd_addr == `MCC_ADDR_CHEN) ? 32'(chen_r) :
        (rd_addr == `MCC_ADDR_STAT) ? {29'h0, hold_r, running, policy_r} :
        32'h0000_0000;

    // address phase capture; data phase is zero wait
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 32'h0000_0000;
        end
        else if (clk_en_in)
        begin
            wr_pend_r <= addr_ok && hwrite_in;
            rd_pend_r <= addr_ok && !hwrite_in;
            if (addr_ok)
                addr_r <= {haddr_in[31:2], 2'b00};
        end
    end

    // read data loaded at the address phase edge; a read right behind a write sees the old word
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            rdata_r <= 32'h0000_0000;
        else if (clk_en_in)
            rdata_r <= (addr_ok && !hwrite_in) ? rd_mux : 32'h0000_0000;
    end
    assign hrdata_out = rdata_r;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    // ****************************************
    // configuration registers
    // ****************************************
    // balancing status comes from another domain: two flops
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            bal_s1_r <= 1'b0;
            bal_s2_r <= 1'b0;
            policy_r <= 1'b0;
            len_r <= 9'(`MCC_PER_RESET);
            chen_r <= '0;
        end
        else if (clk_en_in)
        begin
            bal_s1_r <= balancing_in;
            bal_s2_r <= bal_s1_r;
            if (wr_per)
            begin
                policy_r <= hwdata_in[`MCC_PER_POLICY_BIT];
                len_r <= clamp_len(hwdata_in[8:0]);
            end
            if (wr_chen)
                chen_r <= hwdata_in[CH_NUM-1:0];
        end
    end
    assign period_count_out = len_r;

    // ****************************************
    // cycle sequencer
    // ****************************************
    // hold waits for pause timer only if balancing was running
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        hold_nxt = hold_r;
        pstart_nxt = 1'b0;
        qstart_nxt = 1'b0;
        if (app_hold || sync_hold)
            hold_nxt = 1'b1;
        unique case (state_r)
            MCC_IDLE:
            begin
                if (paired_go || quick_go)
                begin
                    if (sync_hold && bal_s2_r)
                    begin
                        state_nxt = MCC_HOLD_WAIT;
                        cnt_nxt = PAUSE_CYC;
                    end
                    else
                    begin
                        state_nxt = paired_go ? MCC_PAIRED : MCC_QUICK;
                        cnt_nxt = paired_go ? PAIRED_CYC : QUICK_CYC;
                        pstart_nxt = paired_go;
                        qstart_nxt = quick_go;
                    end
                end
                else if (!app_hold)
                    hold_nxt = 1'b0;
            end
            MCC_HOLD_WAIT:
            begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01)
                begin
                    // a held quick cycle resumes as quick, with its own length
                    state_nxt = wait_quick_r ? MCC_QUICK : MCC_PAIRED;
                    cnt_nxt = wait_quick_r ? QUICK_CYC : PAIRED_CYC;
                    pstart_nxt = !wait_quick_r;
                    qstart_nxt = wait_quick_r;
                end
            end
            MCC_PAIRED, MCC_QUICK:
            begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01)
                begin
                    state_nxt = MCC_IDLE;
                    hold_nxt = 1'b0;
                end
            end
        endcase
    end

    // sequencer and pulse registers
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_r <= MCC_IDLE;
            cnt_r <= 8'h00;
            hold_r <= 1'b0;
            pstart_r <= 1'b0;
            qstart_r <= 1'b0;
            cell_r <= 1'b0;
            auxa_r <= 1'b0;
            upd_r <= 1'b0;
            wait_quick_r <= 1'b0;
            busy_r <= 1'b0;
        end
        else if (clk_en_in)
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            hold_r <= hold_nxt;
            busy_r <= (state_nxt == MCC_PAIRED);
            pstart_r <= pstart_nxt;
            qstart_r <= qstart_nxt;
            if (state_r == MCC_IDLE && state_nxt == MCC_HOLD_WAIT)
                wait_quick_r <= quick_go;
            cell_r <= cell_go;
            auxa_r <= auxa_go;
            upd_r <= policy_r ? wr_per : period_end_in;
        end
    end
    assign cell_capture_out = cell_r;
    assign aux_a_capture_out = auxa_r;
    assign periodic_update_out = upd_r;
    assign balance_hold_out = hold_r;
    assign paired_start_out = pstart_r;
    assign paired_busy_out = busy_r; // flop copy of the paired state
    assign quick_start_out = qstart_r;

    // ****************************************
    // assertions
    // ****************************************
    property p_cell_pulse;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        clk_en_in && wr_app && hwdata_in[0] && IS_PRIMARY |=> cell_capture_out;
    endproperty
    a_cell_pulse: assert property (p_cell_pulse) else $error("cell capture missing");

    property p_no_cell_secondary;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        !IS_PRIMARY |-> !cell_capture_out;
    endproperty
    a_no_cell_secondary: assert property (p_no_cell_secondary) else $error("secondary cell capture");

    property p_auxa;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        clk_en_in && wr_app && !hwdata_in[1] |=> !aux_a_capture_out;
    endproperty
    a_auxa: assert property (p_auxa) else $error("aux capture on zero write");

    property p_len_min;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        period_count_out >= 9'h010;
    endproperty
    a_len_min: assert property (p_len_min) else $error("period count below min");

    property p_pulse_single;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        clk_en_in && paired_start_out |=> !paired_start_out;
    endproperty
    a_pulse_single: assert property (p_pulse_single) else $error("start pulse too long");

    property p_no_ch;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        clk_en_in && wr_sync && !any_ch && state_r == MCC_IDLE |=> !paired_start_out && state_r != MCC_PAIRED;
    endproperty
    a_no_ch: assert property (p_no_ch) else $error("paired start without channel");

    property p_quick_ignored;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        clk_en_in && wr_sync && hwdata_in[0] && hwdata_in[1] |=> !quick_start_out;
    endproperty
    a_quick_ignored: assert property (p_quick_ignored) else $error("quick not ignored");

    property p_hold_during;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        clk_en_in && sync_hold && paired_go && !bal_s2_r |=> balance_hold_out && paired_start_out;
    endproperty
    a_hold_during: assert property (p_hold_during) else $error("hold not applied");

    property p_hold_wait;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        clk_en_in && sync_hold && paired_go && bal_s2_r |=> !paired_start_out;
    endproperty
    a_hold_wait: assert property (p_hold_wait) else $error("capture not delayed");

    property p_read_zero;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        rd_pend_r && addr_r == `MCC_ADDR_PER |-> hrdata_out[15:13] == 3'h0 && hrdata_out[11:9] == 3'h0;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("reserved bits nonzero");

    property p_auxa_pulse;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        clk_en_in && wr_app && hwdata_in[1] |=> aux_a_capture_out;
    endproperty
    a_auxa_pulse: assert property (p_auxa_pulse) else $error("aux capture missing");

    property p_auto_update;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        clk_en_in && !policy_r && period_end_in |=> periodic_update_out;
    endproperty
    a_auto_update: assert property (p_auto_update) else $error("auto update missing");

    property p_once_update;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        clk_en_in && policy_r && wr_per |=> periodic_update_out;
    endproperty
    a_once_update: assert property (p_once_update) else $error("write update missing");

    property p_len_keep;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        clk_en_in && wr_per && hwdata_in[8:0] >= 9'h010 |=> period_count_out == $past(hwdata_in[8:0]);
    endproperty
    a_len_keep: assert property (p_len_keep) else $error("period count not kept");

    property p_hold_ignored;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        clk_en_in && wr_sync && !hwdata_in[0] && !hwdata_in[1] && state_r == MCC_IDLE |=> !balance_hold_out;
    endproperty
    a_hold_ignored: assert property (p_hold_ignored) else $error("hold without capture");

    property p_quick_start;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        clk_en_in && wr_sync && hwdata_in[1] && !hwdata_in[0] && !hwdata_in[15]
        && state_r == MCC_IDLE |=> quick_start_out;
    endproperty
    a_quick_start: assert property (p_quick_start) else $error("quick start missing");

    property p_quick_busy;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        clk_en_in && wr_sync && hwdata_in[1] && state_r == MCC_PAIRED |=> !quick_start_out;
    endproperty
    a_quick_busy: assert property (p_quick_busy) else $error("quick during paired");

    property p_paired_busy;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        clk_en_in && wr_sync && hwdata_in[0] && state_r == MCC_PAIRED |=> !paired_start_out;
    endproperty
    a_paired_busy: assert property (p_paired_busy) else $error("paired restart while running");

    c_paired: cover property (@(posedge sys_clk_in) paired_start_out);
    c_quick: cover property (@(posedge sys_clk_in) quick_start_out);
    c_wait: cover property (@(posedge sys_clk_in) state_r == MCC_HOLD_WAIT);
    c_update: cover property (@(posedge sys_clk_in) policy_r && periodic_update_out);

endmodule

`default_nettype wire

// ### testbench/mcc_top_tb.sv
// self-checking testbench for measurement capture control
`timescale 1ns/1ns
`default_nettype none
`include "mcc_map.svh"

module mcc_top_tb;
    // ****************************************
    // bench signals
    // ****************************************
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic balancing = 1'b0;
    logic period_end = 1'b0;
    logic prev_pol;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    logic [31:0] v;
    logic [31:0] seed = 32'h4CC782B5;
    wire logic [31:0] hrdata;
    wire logic [8:0] pcount;
    wire logic hreadyout, hresp, cellc, auxc, upd, pstart, busy, hold, quick;
    wire logic [4:0] pulses;
    wire logic cell_sec;
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;
    int t0;
    int n;

    // one vector of every start pulse, easy to compare in one go
    assign pulses = {cellc, auxc, upd, pstart, quick};

    always #25 sys_clk_in = ~sys_clk_in;

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge sys_clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    mcc_top DUT (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .clk_en_in(1'b1), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hreadyout),
        .balancing_in(balancing), .period_end_in(period_end), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
        .hresp_out(hresp), .cell_capture_out(cellc), .aux_a_capture_out(auxc), .periodic_update_out(upd),
        .period_count_out(pcount), .balance_hold_out(hold), .paired_start_out(pstart),
        .paired_busy_out(busy), .quick_start_out(quick)
    );

    // secondary chain copy on the same bus: it must never capture cell terminals
    mcc_top #(.IS_PRIMARY(1'b0)) DUT_SEC (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .clk_en_in(1'b1), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hreadyout),
        .balancing_in(balancing), .period_end_in(period_end), .hrdata_out(), .hreadyout_out(),
        .hresp_out(), .cell_capture_out(cell_sec), .aux_a_capture_out(), .periodic_update_out(),
        .period_count_out(), .balance_hold_out(), .paired_start_out(), .paired_busy_out(), .quick_start_out()
    );

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    // readback of the periodic register: short counts clamp, reserved bits zero
    function automatic logic [31:0] per_exp(input logic [31:0] w);
        logic [8:0] len;
        len = (w[8:0] < 9'h010) ? 9'h010 : w[8:0];
        return {19'h0, w[12], 3'h0, len};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // single ahb-lite transfer; returns at the data-phase edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge sys_clk_in);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask

    // pulses stand exactly in the cycle after the data phase
    task automatic after_wr(input logic [4:0] exp);
        #1;
        t0 = cyc;
        chk({31'h0, cell_sec}, 32'h0);
        chk({27'h0, pulses}, {27'h0, exp});
        @(posedge sys_clk_in);
        #1;
        chk({27'h0, pulses}, 32'h0);
    endtask

    // one period end, then count update pulses in a short window
    task automatic period_tick(output int k);
        k = 0;
        @(posedge sys_clk_in) period_end <= 1'b1;
        @(posedge sys_clk_in) period_end <= 1'b0;
        repeat (4)
        begin
            #1;
            if (upd === 1'b1) k++;
            @(posedge sys_clk_in);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (2) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        bus(1'b0, `MCC_ADDR_PER, 32'h0, rd);
        chk(rd, 32'h0000_0010);
        chk({23'h0, pcount}, 32'h0000_0010);
        chk({31'h0, hresp}, 32'h0);
        // corner values first, then random words with junk in reserved bits
        prev_pol = 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            case (i)
                0: v = 32'h0;
                1: v = 32'h000F;
                2: v = 32'h0011;
                3: v = 32'h1FFF;
                4: v = 32'hFFFF;
                5: v = 32'h01FF;
                default:
                begin
                    seed = xs(seed);
                    v = seed;
                end
            endcase
            wr(`MCC_ADDR_PER, v);
            #1;
            if (prev_pol === v[12]) chk({31'h0, upd}, {31'h0, v[12]});
            prev_pol = v[12];
            bus(1'b0, `MCC_ADDR_PER, 32'h0, rd);
            chk(rd, per_exp(v));
            chk({23'h0, pcount}, per_exp(v) & 32'h1FF);
        end
        // auto policy follows period ends, once policy does not
        wr(`MCC_ADDR_PER, 32'h0020);
        period_tick(n);
        chk(n, 32'h1);
        wr(`MCC_ADDR_PER, 32'h1020);
        period_tick(n);
        chk(n, 32'h0);
        // capture triggers: each one alone, both, and zero or unrelated bits
        wr(`MCC_ADDR_APP, 32'h1);
        after_wr(5'b10000);
        wr(`MCC_ADDR_APP, 32'h2);
        after_wr(5'b01000);
        wr(`MCC_ADDR_APP, 32'h3);
        after_wr(5'b11000);
        wr(`MCC_ADDR_APP, 32'h0);
        after_wr(5'b00000);
        wr(`MCC_ADDR_APP, 32'h7FFC);
        after_wr(5'b00000);
        // paired start refused while no channel is enabled
        wr(`MCC_ADDR_CHEN, 32'h0);
        wr(`MCC_ADDR_SYNC, 32'h1);
        after_wr(5'b00000);
        seed = xs(seed);
        wr(`MCC_ADDR_CHEN, (seed[15:0] == 16'h0) ? 32'h1 : {16'h0, seed[15:0]});
        // quick together with start loses; both refused while busy
        wr(`MCC_ADDR_SYNC, 32'h3);
        after_wr(5'b00010);
        n = t0;
        wr(`MCC_ADDR_SYNC, 32'h1);
        after_wr(5'b00000);
        wr(`MCC_ADDR_SYNC, 32'h2);
        after_wr(5'b00000);
        bus(1'b0, `MCC_ADDR_SYNC, 32'h0, rd);
        chk(rd, 32'h0);
        while (busy === 1'b1 && cyc - n < 200)
        begin
            @(posedge sys_clk_in);
            #1;
        end
        chk(cyc - n, `MCC_PAIRED_CYC);
        wr(`MCC_ADDR_SYNC, 32'h2);
        after_wr(5'b00001);
        repeat (12) @(posedge sys_clk_in);
        wr(`MCC_ADDR_SYNC, 32'h8000);
        after_wr(5'b00000);
        chk({31'h0, hold}, 32'h0);
        // hold while balancing runs delays the start by the pause time
        @(posedge sys_clk_in) balancing <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        wr(`MCC_ADDR_SYNC, 32'h8001);
        n = 0;
        while (pstart !== 1'b1 && n < 100)
        begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        chk(n, `MCC_PAUSE_CYC);
        chk({31'h0, hold}, 32'h1);
        @(posedge sys_clk_in) balancing <= 1'b0;
        // unmapped place reads zero and ignores writes
        wr(32'h0000_6100, 32'hFFFF);
        after_wr(5'b00000);
        bus(1'b0, 32'h0000_6100, 32'h0, rd);
        chk(rd, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
